// file: rtl/mpr_pkg.sv
package mpr_pkg;

  // Transfer encoding of the region registers
  localparam logic [3:0] COPROC_SYS         = 4'hf;
  localparam logic [3:0] CRN_REGION         = 4'h6;
  localparam logic [2:0] OPC1_SEL           = 3'h0;
  localparam logic [3:0] CRM_SEL            = 4'h3;
  localparam logic [2:0] OPC2_LIMIT_SEL     = 3'h1;
  localparam logic [1:0] OPC1_NUM_PREFIX    = 2'h0;
  localparam logic       CRM_NUM_PREFIX     = 1'b1;
  localparam logic [1:0] OPC2_BASE_SUFFIX   = 2'h0;
  localparam logic [1:0] OPC2_LIMIT_SUFFIX  = 2'h1;
  localparam int         DIRECT_REGIONS     = 32;

  // Privilege level of the requester
  localparam logic [1:0] LVL_UNPRIV         = 2'h0;
  localparam logic [1:0] LVL_KERNEL         = 2'h1;
  localparam logic [1:0] LVL_HYP            = 2'h2;

  // Field layout of base and limit registers
  localparam int         ADDR_LSB           = 6;
  localparam logic [5:0] LIMIT_LOW_FILL     = 6'h3f;
  localparam logic [5:0] BASE_LOW_FILL      = 6'h00;
  localparam logic [31:0] BASE_KEEP_MASK    = 32'hffffffdf;
  localparam logic [31:0] LIMIT_KEEP_MASK   = 32'hffffffcf;
  localparam int         XN_BIT             = 0;
  localparam int         AP_LSB             = 1;
  localparam int         EN_BIT             = 0;
  localparam int         ATTR_LSB           = 1;
  localparam int         ATTR_SLOT_W        = 8;
  localparam logic       EN_RESET           = 1'b0;

  // Permission field encodings
  localparam logic [1:0] AP_KRW_UNONE       = 2'h0;
  localparam logic [1:0] AP_KRW_URW         = 2'h1;
  localparam logic [1:0] AP_KRO_UNONE       = 2'h2;
  localparam logic [1:0] AP_KRO_URO         = 2'h3;

endpackage

// file: rtl/mpr_decode.sv
`timescale 1ns/1ps
module mpr_decode
#(
  parameter int NUM_REGIONS = 16
)
(
  // Transfer encoding
  input  wire logic [3:0] coproc,
  input  wire logic [2:0] opc1,
  input  wire logic [3:0] crn,
  input  wire logic [3:0] crm,
  input  wire logic [2:0] opc2,
  // Decode result
  output logic            is_base_num,
  output logic            is_limit_num,
  output logic            is_limit_sel,
  output logic [4:0]      num_index,
  output logic            num_alloc
);

  logic       space_hit;
  logic       num_shape;

  // Index gathered from opc1, CRm and opc2 bits
  assign space_hit    = (coproc == mpr_pkg::COPROC_SYS)
                        && (crn == mpr_pkg::CRN_REGION); // RULE2 RULE3
  assign num_shape    = (opc1[2:1] == mpr_pkg::OPC1_NUM_PREFIX)
                        && (crm[3] == mpr_pkg::CRM_NUM_PREFIX);
  assign num_index    = {opc1[0], crm[2:0], opc2[2]};
  assign is_base_num  = space_hit && num_shape
                        && (opc2[1:0] == mpr_pkg::OPC2_BASE_SUFFIX); // RULE2
  assign is_limit_num = space_hit && num_shape
                        && (opc2[1:0] == mpr_pkg::OPC2_LIMIT_SUFFIX); // RULE3
  assign is_limit_sel = space_hit && (opc1 == mpr_pkg::OPC1_SEL) && (crm == mpr_pkg::CRM_SEL)
                        && (opc2 == mpr_pkg::OPC2_LIMIT_SEL); // RULE16

  // Numbered encodings past the implemented count are unallocated
  assign num_alloc    = (int'(num_index) < NUM_REGIONS); // RULE4 RULE15

endmodule

// file: rtl/mpr_match.sv
`timescale 1ns/1ps
module mpr_match
#(
  parameter int NUM_REGIONS = 16
)
(
  // Region programming
  input  wire logic [NUM_REGIONS-1:0][31:0] base,
  input  wire logic [NUM_REGIONS-1:0][31:0] limit,
  // Address under test
  input  wire logic [31:0]                  addr,
  output logic      [NUM_REGIONS-1:0]       hit
);

  // One comparator pair per region; bounds are inclusive at both ends
  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g++)
    begin : g_region
      logic [31:0] lo;
      logic [31:0] hi;
      assign lo     = {base[g][31:mpr_pkg::ADDR_LSB], mpr_pkg::BASE_LOW_FILL}; // RULE17
      assign hi     = {limit[g][31:mpr_pkg::ADDR_LSB], mpr_pkg::LIMIT_LOW_FILL}; // RULE11
      assign hit[g] = limit[g][mpr_pkg::EN_BIT] && (addr >= lo) && (addr <= hi); // RULE19
    end
  endgenerate

endmodule

// file: rtl/mpr_top.sv
// Overview of operation
// RULE1 - Permission field: 00 kernel rw, 01 all rw, 10 kernel ro, 11 all ro.
// RULE2 - Numbered base n sits at opc1 00:n[4], CRm 1:n[3:1], opc2 n[0]:00.
// RULE3 - Numbered limit n uses the same index formation in the region space.
// RULE4 - Numbered encodings at or past implemented region count are undefined.
// RULE5 - Kernel and hypervisor may access; unprivileged never; TRAP_GENERAL_EXCEPTIONS set leaves hypervisor.
// RULE6 - Kernel writes to region registers trap when write trap control is set.
// RULE7 - Kernel reads of region registers trap when read trap control is set.
// RULE8 - Kernel accesses to numbered registers trap when CRn-10 trap bit set.
// RULE9 - Kernel accesses to selected limit register trap when CRn-6 trap bit set.
// RULE10 - Selected limit register reaches the region named by the selector.
// RULE11 - Upper limit is limit field as bits 31:6 with 0x3F below.
// RULE12 - Attribute index 0-3 picks low indirection slots, 4-7 high slots.
// RULE13 - Bit 0 of each limit register enables region and resets to 0.
// RULE14 - Other fields stay unknown after reset; software programs them first.
// RULE15 - Direct numbered registers cover only the first 32 regions.
// RULE16 - Selected limit register decodes at opc1 000, CRm 0011, opc2 001.
// RULE17 - Lower base is base field as bits 31:6 with zeros below.
// RULE18 - Eight-bit selector picks region; software keeps it below region count.
// RULE19 - Address matches a region only when enabled and within inclusive bounds.
`timescale 1ns/1ps
module mpr_top
#(
  parameter int NUM_REGIONS = 16
)
(
  // Clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        CE,
  // Coprocessor transfer request
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic [1:0]  REQ_LEVEL,
  input  wire logic [3:0]  REQ_COPROC,
  input  wire logic [2:0]  REQ_OPC1,
  input  wire logic [3:0]  REQ_CRN,
  input  wire logic [3:0]  REQ_CRM,
  input  wire logic [2:0]  REQ_OPC2,
  input  wire logic [31:0] REQ_WDATA,
  // Hypervisor controls and selector
  input  wire logic        TRAP_GENERAL_EXCEPTIONS,
  input  wire logic        TRAP_VM_WRITES,
  input  wire logic        TRAP_VM_READS,
  input  wire logic        CRN10_TRAP_BIT,
  input  wire logic        CRN6_TRAP_BIT,
  input  wire logic [7:0]  REGION_SELECTOR,
  // Attribute indirection registers
  input  wire logic [31:0] ATTRIBUTE_INDIRECTION_LOW,
  input  wire logic [31:0] ATTRIBUTE_INDIRECTION_HIGH,
  // Transfer answer
  output logic             RSP_VALID,
  output logic             RSP_UNDEF,
  output logic             RSP_TRAP,
  output logic [31:0]      RSP_RDATA,
  // Address lookup
  input  wire logic        CHK_VALID,
  input  wire logic [31:0] CHK_ADDR,
  output logic             CHK_DONE,
  output logic             CHK_HIT,
  output logic [7:0]       CHK_REGION,
  output logic             CHK_KERNEL_RD,
  output logic             CHK_KERNEL_WR,
  output logic             CHK_UNPRIV_RD,
  output logic             CHK_UNPRIV_WR,
  output logic             CHK_XN,
  output logic [7:0]       CHK_ATTR
);

  // Elaboration checks on the region count
  if (NUM_REGIONS < 1 || NUM_REGIONS > 256)
  begin : g_bad_count
    $error("NUM_REGIONS must lie in 1..256");
  end

  // Whole block state; region fields other than the enable have no reset
  typedef struct packed {
    logic [NUM_REGIONS-1:0][31:0] base;
    logic [NUM_REGIONS-1:0][31:0] limit;
    logic                         rsp_valid;
    logic                         rsp_undef;
    logic                         rsp_trap;
    logic [31:0]                  rsp_rdata;
    logic                         chk_done;
    logic                         chk_hit;
    logic [7:0]                   chk_region;
    logic                         chk_krd;
    logic                         chk_kwr;
    logic                         chk_urd;
    logic                         chk_uwr;
    logic                         chk_xn;
    logic [7:0]                   chk_attr;
  } mpr_state_t;

  // Registered state and its next value
  mpr_state_t             st_ff;
  mpr_state_t             nxt_st_ff;

  logic                   is_base_num;
  logic                   is_limit_num;
  logic                   is_limit_sel;
  logic [4:0]             num_index;
  logic                   num_alloc;
  logic [NUM_REGIONS-1:0] hit_vec;

  // Encoding decode of the transfer
  mpr_decode #(
    .NUM_REGIONS (NUM_REGIONS)
  ) u_decode (
    .coproc       (REQ_COPROC),
    .opc1         (REQ_OPC1),
    .crn          (REQ_CRN),
    .crm          (REQ_CRM),
    .opc2         (REQ_OPC2),
    .is_base_num  (is_base_num),
    .is_limit_num (is_limit_num),
    .is_limit_sel (is_limit_sel),
    .num_index    (num_index),
    .num_alloc    (num_alloc)
  );

  // Per-region address comparators
  mpr_match #(
    .NUM_REGIONS (NUM_REGIONS)
  ) u_match (
    .base  (st_ff.base),
    .limit (st_ff.limit),
    .addr  (CHK_ADDR),
    .hit   (hit_vec)
  );

  // Access outcome of the current request
  logic       any_reg;
  logic       sel_ok;
  logic       lvl_undef;
  logic       is_kernel;
  logic       trap_now;
  logic       undef_now;
  logic [7:0] tgt_index;
  logic       tgt_is_limit;
  logic       tgt_ok;

  always_comb
  begin
    any_reg   = is_base_num || is_limit_num || is_limit_sel;
    // Out-of-range selector is software's fault; treat as read zero, write ignored
    sel_ok    = (int'(REGION_SELECTOR) < NUM_REGIONS); // RULE18
    is_kernel = (REQ_LEVEL == mpr_pkg::LVL_KERNEL);
    // Unprivileged never; kernel level does not exist while TRAP_GENERAL_EXCEPTIONS is set
    lvl_undef = !((REQ_LEVEL == mpr_pkg::LVL_HYP)
                  || (is_kernel && !TRAP_GENERAL_EXCEPTIONS)); // RULE5
    undef_now = any_reg && (lvl_undef || ((is_base_num || is_limit_num) && !num_alloc)); // RULE4
    trap_now  = any_reg && !undef_now && is_kernel
                && ((REQ_WRITE && TRAP_VM_WRITES) // RULE6
                    || (!REQ_WRITE && TRAP_VM_READS) // RULE7
                    || ((is_base_num || is_limit_num) && CRN10_TRAP_BIT) // RULE8
                    || (is_limit_sel && CRN6_TRAP_BIT)); // RULE9
    // Target of the transfer; the selector path can reach past region 31
    tgt_is_limit = is_limit_num || is_limit_sel;
    if (is_limit_sel)
    begin
      tgt_index = REGION_SELECTOR; // RULE10
      tgt_ok    = sel_ok;
    end
    else
    begin
      tgt_index = {3'h0, num_index}; // RULE15
      tgt_ok    = num_alloc;
    end
  end

  // Lowest numbered matching region wins
  logic [7:0] win_idx;
  logic       win_hit;

  always_comb
  begin
    win_idx = 8'h00;
    win_hit = 1'b0;
    // Scan downward so the lowest index is written last
    for (int i = NUM_REGIONS - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        win_idx = 8'(i);
        win_hit = 1'b1;
      end
    end
  end

  // Attributes and permissions of the winning region
  logic [31:0] win_base;
  logic [31:0] win_limit;
  logic [2:0]  attr_sel;
  logic [31:0] attr_word;
  logic [1:0]  perm;
  logic        krd;
  logic        kwr;
  logic        urd;
  logic        uwr;

  always_comb
  begin
    // Plain mux over the regions; an eight-bit index never overruns the array
    win_base  = st_ff.base[0];
    win_limit = st_ff.limit[0];
    for (int i = 0; i < NUM_REGIONS; i++)
    begin
      if (win_idx == 8'(i))
      begin
        win_base  = st_ff.base[i];
        win_limit = st_ff.limit[i];
      end
    end
    attr_sel  = win_limit[mpr_pkg::ATTR_LSB +: 3];
    // Top index bit chooses the indirection register, low two bits the slot
    attr_word = attr_sel[2] ? ATTRIBUTE_INDIRECTION_HIGH : ATTRIBUTE_INDIRECTION_LOW; // RULE12
    perm      = win_base[mpr_pkg::AP_LSB +: 2];
    krd       = 1'b0;
    kwr       = 1'b0;
    urd       = 1'b0;
    uwr       = 1'b0;
    // Permission and execute-never live in the base word
    case (perm) // RULE1
      mpr_pkg::AP_KRW_UNONE:
      begin
        krd = 1'b1;
        kwr = 1'b1;
      end
      mpr_pkg::AP_KRW_URW:
      begin
        krd = 1'b1;
        kwr = 1'b1;
        urd = 1'b1;
        uwr = 1'b1;
      end
      mpr_pkg::AP_KRO_UNONE:
      begin
        krd = 1'b1;
      end
      mpr_pkg::AP_KRO_URO:
      begin
        krd = 1'b1;
        urd = 1'b1;
      end
      default:
      begin
        krd = 1'b0;
      end
    endcase
  end

  // Next state: register writes, transfer answer, lookup answer
  always_comb
  begin
    nxt_st_ff           = st_ff;
    nxt_st_ff.rsp_valid = REQ_VALID && any_reg;
    nxt_st_ff.rsp_undef = REQ_VALID && undef_now;
    nxt_st_ff.rsp_trap  = REQ_VALID && trap_now;
    nxt_st_ff.rsp_rdata = 32'h0000_0000;
    // Refused or trapped transfers leave every register untouched
    if (REQ_VALID && any_reg && !undef_now && !trap_now && tgt_ok)
    begin
      for (int i = 0; i < NUM_REGIONS; i++)
      begin
        if (tgt_index == 8'(i))
        begin
          if (REQ_WRITE && tgt_is_limit)
          begin
            nxt_st_ff.limit[i] = REQ_WDATA & mpr_pkg::LIMIT_KEEP_MASK; // RULE13
          end
          else if (REQ_WRITE)
          begin
            nxt_st_ff.base[i] = REQ_WDATA & mpr_pkg::BASE_KEEP_MASK;
          end
          else if (tgt_is_limit)
          begin
            nxt_st_ff.rsp_rdata = st_ff.limit[i];
          end
          else
          begin
            nxt_st_ff.rsp_rdata = st_ff.base[i];
          end
        end
      end
    end
    // Lookup answer, one cycle after the address
    nxt_st_ff.chk_done   = CHK_VALID;
    nxt_st_ff.chk_hit    = CHK_VALID && win_hit; // RULE19
    nxt_st_ff.chk_region = win_hit ? win_idx : 8'h00;
    nxt_st_ff.chk_krd    = CHK_VALID && win_hit && krd;
    nxt_st_ff.chk_kwr    = CHK_VALID && win_hit && kwr;
    nxt_st_ff.chk_urd    = CHK_VALID && win_hit && urd;
    nxt_st_ff.chk_uwr    = CHK_VALID && win_hit && uwr;
    nxt_st_ff.chk_xn     = CHK_VALID && win_hit && win_base[mpr_pkg::XN_BIT];
    // Attribute byte is zero on a miss so a stale slot never leaks out
    nxt_st_ff.chk_attr   = win_hit
                           ? attr_word[attr_sel[1:0] * mpr_pkg::ATTR_SLOT_W +: mpr_pkg::ATTR_SLOT_W]
                           : 8'h00;
    // Reset clears only enables and answers; addresses stay unknown by design
    if (RST)
    begin
      for (int i = 0; i < NUM_REGIONS; i++)
      begin
        nxt_st_ff.limit[i][mpr_pkg::EN_BIT] = mpr_pkg::EN_RESET; // RULE13 RULE14
      end
      nxt_st_ff.rsp_valid  = 1'b0;
      nxt_st_ff.rsp_undef  = 1'b0;
      nxt_st_ff.rsp_trap   = 1'b0;
      nxt_st_ff.rsp_rdata  = 32'h0000_0000;
      nxt_st_ff.chk_done   = 1'b0;
      nxt_st_ff.chk_hit    = 1'b0;
      nxt_st_ff.chk_region = 8'h00;
      nxt_st_ff.chk_krd    = 1'b0;
      nxt_st_ff.chk_kwr    = 1'b0;
      nxt_st_ff.chk_urd    = 1'b0;
      nxt_st_ff.chk_uwr    = 1'b0;
      nxt_st_ff.chk_xn     = 1'b0;
      nxt_st_ff.chk_attr   = 8'h00;
    end
  end

  // Reset acts even while the enable is low
  always_ff @(posedge CLOCK)
  begin
    if (CE || RST)
    begin
      st_ff <= nxt_st_ff;
    end
  end

  // Outputs straight from the state register
  assign RSP_VALID     = st_ff.rsp_valid;
  assign RSP_UNDEF     = st_ff.rsp_undef;
  assign RSP_TRAP      = st_ff.rsp_trap;
  assign RSP_RDATA     = st_ff.rsp_rdata;
  assign CHK_DONE      = st_ff.chk_done;
  assign CHK_HIT       = st_ff.chk_hit;
  assign CHK_REGION    = st_ff.chk_region;
  assign CHK_KERNEL_RD = st_ff.chk_krd;
  assign CHK_KERNEL_WR = st_ff.chk_kwr;
  assign CHK_UNPRIV_RD = st_ff.chk_urd;
  assign CHK_UNPRIV_WR = st_ff.chk_uwr;
  assign CHK_XN        = st_ff.chk_xn;
  assign CHK_ATTR      = st_ff.chk_attr;

endmodule

// file: bench/mpr_checker.sv
`timescale 1ns/1ps
module mpr_checker
#(
  parameter int NUM_REGIONS = 16
)
(
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       CE,
  // Transfer request
  input wire logic       REQ_VALID,
  input wire logic       REQ_WRITE,
  input wire logic [1:0] REQ_LEVEL,
  input wire logic [3:0] REQ_COPROC,
  input wire logic [2:0] REQ_OPC1,
  input wire logic [3:0] REQ_CRN,
  input wire logic [3:0] REQ_CRM,
  input wire logic [2:0] REQ_OPC2,
  // Hypervisor controls
  input wire logic       TRAP_GENERAL_EXCEPTIONS,
  input wire logic       TRAP_VM_WRITES,
  input wire logic       TRAP_VM_READS,
  input wire logic       CRN10_TRAP_BIT,
  input wire logic       CRN6_TRAP_BIT,
  // Answers
  input wire logic       RSP_VALID,
  input wire logic       RSP_UNDEF,
  input wire logic       RSP_TRAP,
  input wire logic       CHK_VALID,
  input wire logic       CHK_DONE
);
  logic sel_enc;
  logic num_enc;
  logic kern;
  // Selected limit and numbered limit 0, which exists for any region count
  assign sel_enc = REQ_COPROC == 4'hf && REQ_CRN == 4'h6
                   && {REQ_OPC1, REQ_CRM, REQ_OPC2} == 10'h019;
  assign num_enc = REQ_COPROC == 4'hf && REQ_CRN == 4'h6
                   && {REQ_OPC1, REQ_CRM, REQ_OPC2} == 10'h041;
  assign kern    = REQ_VALID && CE && REQ_LEVEL == mpr_pkg::LVL_KERNEL && NUM_REGIONS > 0;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // Kernel requests that pass the level check, and a trap-only answer
  sequence s_ksel;
    kern && sel_enc && !TRAP_GENERAL_EXCEPTIONS;
  endsequence
  sequence s_knum;
    kern && num_enc && !TRAP_GENERAL_EXCEPTIONS;
  endsequence
  sequence s_trap;
    RSP_VALID && RSP_TRAP && !RSP_UNDEF;
  endsequence

  property p_unpriv;
    REQ_VALID && CE && sel_enc && REQ_LEVEL == mpr_pkg::LVL_UNPRIV |=> RSP_VALID && RSP_UNDEF;
  endproperty
  a_unpriv: assert property (p_unpriv) else $error("unprivileged access not refused");
  property p_tge;
    kern && sel_enc && TRAP_GENERAL_EXCEPTIONS |=> RSP_VALID && RSP_UNDEF;
  endproperty
  a_tge: assert property (p_tge) else $error("kernel access under tge not refused");
  property p_hyp;
    REQ_VALID && CE && REQ_LEVEL == mpr_pkg::LVL_HYP |=> !RSP_TRAP;
  endproperty
  a_hyp: assert property (p_hyp) else $error("hypervisor access trapped");
  property p_tvm;
    s_ksel ##0 (REQ_WRITE && TRAP_VM_WRITES) |=> s_trap;
  endproperty
  a_tvm: assert property (p_tvm) else $error("write trap missing");
  property p_trap_vm_reads;
    s_ksel ##0 (!REQ_WRITE && TRAP_VM_READS) |=> s_trap;
  endproperty
  a_trap_vm_reads: assert property (p_trap_vm_reads) else $error("read trap missing");
  property p_t10;
    s_knum ##0 CRN10_TRAP_BIT |=> s_trap;
  endproperty
  a_t10: assert property (p_t10) else $error("numbered trap missing");
  property p_t6;
    s_ksel ##0 CRN6_TRAP_BIT |=> s_trap;
  endproperty
  a_t6: assert property (p_t6) else $error("selected trap missing");
  property p_look;
    CE && CHK_VALID |=> CHK_DONE;
  endproperty
  a_look: assert property (p_look) else $error("lookup answer missing");
endmodule

// file: bench/mpr_core.sv
`timescale 1ns/1ps
module mpr_core
(
  // Clock
  input  wire logic        CLOCK,
  // Request, idle at time zero; only the region space is addressed
  output logic             REQ_VALID = 1'b0,
  output logic             REQ_WRITE = 1'b0,
  output logic [1:0]       REQ_LEVEL = 2'h1,
  output logic [3:0]       REQ_COPROC = 4'hf,
  output logic [2:0]       REQ_OPC1 = 3'h0,
  output logic [3:0]       REQ_CRN = 4'h6,
  output logic [3:0]       REQ_CRM = 4'h0,
  output logic [2:0]       REQ_OPC2 = 3'h0,
  output logic [31:0]      REQ_WDATA = 32'h0,
  // Answer
  input  wire logic        RSP_VALID,
  input  wire logic        RSP_UNDEF,
  input  wire logic        RSP_TRAP,
  input  wire logic [31:0] RSP_RDATA
);
  // Launch after an edge, hold one cycle, take the answer after the next
  task automatic xfer(input logic wr, input logic [1:0] lv, input logic [2:0] o1,
                      input logic [3:0] cm, input logic [2:0] o2, input logic [31:0] wd,
                      output logic [2:0] fl, output logic [31:0] rd);
    @(posedge CLOCK);
    #1;
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_LEVEL = lv;
    REQ_OPC1  = o1;
    REQ_CRM   = cm;
    REQ_OPC2  = o2;
    REQ_WDATA = wd;
    @(posedge CLOCK);
    #1;
    fl = {RSP_VALID, RSP_UNDEF, RSP_TRAP};
    rd = RSP_RDATA;
    REQ_VALID = 1'b0;
    REQ_WDATA = ~wd; // Stale data must not pass for a fresh word
  endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int         NR  = 16;
  localparam logic [2:0] OK  = 3'b100;
  localparam logic [2:0] UND = 3'b110;
  localparam logic [2:0] TRP = 3'b101;
  logic        CLOCK = 1'b0, RST = 1'b1, CE = 1'b1, CHK_VALID = 1'b0;
  logic        TRAP_GENERAL_EXCEPTIONS = 1'b0, TRAP_VM_WRITES = 1'b0, TRAP_VM_READS = 1'b0;
  logic        CRN10_TRAP_BIT = 1'b0, CRN6_TRAP_BIT = 1'b0;
  logic        REQ_VALID, REQ_WRITE, RSP_VALID, RSP_UNDEF, RSP_TRAP, CHK_DONE, CHK_HIT;
  logic        CHK_KERNEL_RD, CHK_KERNEL_WR, CHK_UNPRIV_RD, CHK_UNPRIV_WR, CHK_XN;
  logic [1:0]  REQ_LEVEL;
  logic [2:0]  REQ_OPC1, REQ_OPC2, fl;
  logic [3:0]  REQ_COPROC, REQ_CRN, REQ_CRM;
  logic [7:0]  REGION_SELECTOR = 8'h00, CHK_REGION, CHK_ATTR;
  logic [31:0] REQ_WDATA, RSP_RDATA, rd, CHK_ADDR = 32'h0;
  logic [31:0] ATTRIBUTE_INDIRECTION_LOW = 32'h44332211;
  logic [31:0] ATTRIBUTE_INDIRECTION_HIGH = 32'h88776655;
  int          n_fail = 0, checks_done = 0, cyc = 0;

  mpr_top #(.NUM_REGIONS(NR)) uut (.*);
  mpr_core core (.*);

  // 25 MHz clock
  always #20 CLOCK = ~CLOCK;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Numbered and selected register transfers
  task automatic num(input logic wr, input logic [1:0] lv, input logic [4:0] n,
                     input logic lim, input logic [31:0] wd);
    core.xfer(wr, lv, {2'b00, n[4]}, {1'b1, n[3:1]}, {n[0], 1'b0, lim}, wd, fl, rd);
  endtask
  task automatic sel(input logic wr, input logic [1:0] lv);
    core.xfer(wr, lv, 3'h0, 4'h3, 3'h1, 32'h7000_0a0a, fl, rd);
  endtask

  task automatic look(input logic [31:0] a);
    @(posedge CLOCK);
    #1;
    CHK_VALID = 1'b1;
    CHK_ADDR  = a;
    @(posedge CLOCK);
    #1;
    CHK_VALID = 1'b0;
    CHK_ADDR  = ~a;
  endtask

  task automatic t_reset;
    num(1'b0, 2'h2, 5'd0, 1'b1, 32'h0);
    chk("reset enable", 32'h0, {31'h0, rd[0]});
    look(32'h0);
    chk("reset hit", 32'h0, {31'h0, CHK_HIT});
  endtask

  task automatic t_regs;
    for (int n = 0; n < NR; n++)
    begin
      num(1'b1, 2'h2, 5'(n), 1'b0, {3'h5, 5'(n), 24'hc0ffee});
      num(1'b1, 2'h2, 5'(n), 1'b1, {5'(n), 3'h3, 24'hbeef3e});
      num(1'b0, 2'h1, 5'(n), 1'b0, 32'h0);
      chk("base", {3'h5, 5'(n), 24'hc0ffee} & mpr_pkg::BASE_KEEP_MASK, rd);
      num(1'b0, 2'h1, 5'(n), 1'b1, 32'h0);
      chk("limit", {5'(n), 3'h3, 24'hbeef3e} & mpr_pkg::LIMIT_KEEP_MASK, rd);
    end
    num(1'b0, 2'h1, 5'd16, 1'b0, 32'h0);
    chk("index 16", 32'(UND), 32'(fl));
    num(1'b1, 2'h2, 5'd31, 1'b1, 32'h0);
    chk("index 31", 32'(UND), 32'(fl));
  endtask

  task automatic t_sel;
    REGION_SELECTOR = 8'd5;
    sel(1'b1, 2'h1);
    num(1'b0, 2'h1, 5'd5, 1'b1, 32'h0);
    chk("selected", 32'h7000_0a0a, rd);
    REGION_SELECTOR = 8'd20;
    sel(1'b0, 2'h1);
    chk("far selector flags", 32'(OK), 32'(fl));
    chk("far selector data", 32'h0, rd);
  endtask

  task automatic t_access;
    for (int k = 0; k < 8; k++)
    begin
      TRAP_GENERAL_EXCEPTIONS = k[2];
      sel(1'b0, k[1:0]);
      chk("level", (k[1:0] == 2 || (k[1:0] == 1 && !k[2])) ? OK : UND, 32'(fl));
    end
    TRAP_GENERAL_EXCEPTIONS = 1'b0;
  endtask

  // One trap control at a time, read and write, selected and numbered
  task automatic t_traps;
    logic [3:0] t;
    logic       tr;
    for (int k = 0; k < 16; k++)
    begin
      t = 4'b0001 << k[3:2];
      {TRAP_VM_WRITES, TRAP_VM_READS, CRN10_TRAP_BIT, CRN6_TRAP_BIT} = t;
      tr = (k[0] & t[3]) | (!k[0] & t[2]) | (!k[1] & t[1]) | (k[1] & t[0]);
      if (k[1])
        sel(k[0], 2'h1);
      else
        num(k[0], 2'h1, 5'd0, 1'b1, 32'h0);
      chk("kernel trap", tr ? TRP : OK, 32'(fl));
      num(k[0], 2'h2, 5'd0, 1'b1, 32'h0);
      chk("hyp trap", 32'(OK), 32'(fl));
    end
    {TRAP_VM_WRITES, TRAP_VM_READS, CRN10_TRAP_BIT, CRN6_TRAP_BIT} = 4'h0;
  endtask

  // Region 2 spans 0x20000040 to 0x200000bf; base goes in first, then attribute and enable in one limit write
  task automatic t_match;
    logic [63:0] attrs;
    logic [4:0]  pm;
    logic [4:0]  pg;
    attrs = {ATTRIBUTE_INDIRECTION_HIGH, ATTRIBUTE_INDIRECTION_LOW};
    for (int k = 0; k < 8; k++)
    begin
      num(1'b1, 2'h2, 5'd2, 1'b0, 32'h2000_0040 | 32'({k[1:0], k[2]}));
      num(1'b1, 2'h2, 5'd2, 1'b1, 32'h2000_0080 | 32'({k[2:0], 1'b1}));
      look(k[0] ? 32'h2000_00bf : 32'h2000_0040);
      chk("hit", 32'h302, {22'h0, CHK_DONE, CHK_HIT, CHK_REGION});
      pm = {1'b1, !k[1], k[0], k[1:0] == 2'b01, k[2]};
      pg = {CHK_KERNEL_RD, CHK_KERNEL_WR, CHK_UNPRIV_RD, CHK_UNPRIV_WR, CHK_XN};
      chk("perms", 32'(pm), 32'(pg));
      chk("attr", 32'(attrs[8*k +: 8]), 32'(CHK_ATTR));
    end
    look(32'h2000_003f);
    chk("below base", 32'h0, {31'h0, CHK_HIT});
    look(32'h2000_00c0);
    chk("above limit", 32'h0, {31'h0, CHK_HIT});
    num(1'b1, 2'h2, 5'd2, 1'b1, 32'h2000_0080);
    look(32'h2000_0040);
    chk("disabled", 32'h0, {31'h0, CHK_HIT});
  endtask

  // Enable low freezes writes; a mid-run reset still clears enables and answers
  task automatic t_hold;
    num(1'b1, 2'h2, 5'd2, 1'b1, 32'h2000_0081);
    CE = 1'b0;
    num(1'b1, 2'h2, 5'd2, 1'b1, 32'h2000_0080);
    CE = 1'b1;
    num(1'b0, 2'h2, 5'd2, 1'b1, 32'h0);
    chk("frozen write", 32'h2000_0081, rd);
    CE  = 1'b0;
    RST = 1'b1;
    @(posedge CLOCK);
    #1;
    chk("reset answer", 32'h0, {31'h0, RSP_VALID});
    RST = 1'b0;
    CE  = 1'b1;
    num(1'b0, 2'h2, 5'd2, 1'b1, 32'h0);
    chk("mid-run reset enable", 32'h0, {31'h0, rd[0]});
    look(32'h2000_0040);
    chk("hit after reset", 32'h0, {31'h0, CHK_HIT});
  endtask

  // Reset, then each scenario in turn
  initial
  begin
    repeat (20) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    t_reset();
    t_regs();
    t_sel();
    t_access();
    t_traps();
    t_match();
    t_hold();
    print_verdict();
  end
endmodule

bind mpr_top mpr_checker #(.NUM_REGIONS(NUM_REGIONS)) u_chk (.*);
